//--- hdl/lvm_pkg.sv
// Constants, register map and carrier types of the limit value monitor
package lvm_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int          N_CO2       = 4;
	localparam int          N_HUM       = 2;
	localparam int          N_LIM       = N_CO2 + N_HUM;
	localparam int          VAL_W       = 16;
	localparam int          ADDR_W      = 8;

	// ----------------------------------------------------------------
	// Time base
	// ----------------------------------------------------------------
	localparam int          CLK_MHZ     = 100;
	localparam int          TICK_MS     = 100;
	localparam int          TICK_CYCLES = TICK_MS * CLK_MHZ * 1000;
	localparam int          BASE_S      = 10;
	localparam logic [15:0] BASE_TICKS  = 16'(BASE_S * 1000 / TICK_MS);
	localparam int          TICK_CNT_W  = 24;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_STATUS = 8'h04;
	localparam logic [3:0]  LIM_BANK0   = 4'h1;
	localparam logic [3:0]  OFS_LEVEL   = 4'h0;
	localparam logic [3:0]  OFS_HYST    = 4'h4;
	localparam logic [3:0]  OFS_MODE    = 4'h8;
	localparam logic [3:0]  OFS_TIMING  = 4'hc;

	// Control register fields
	localparam int          CTRL_CO2_LSB = 0;
	localparam int          CTRL_HUM_LSB = 4;
	localparam int          CTRL_RELOAD  = 8;
	localparam logic [2:0]  CO2_CNT_RST  = 3'h4;
	localparam logic [1:0]  HUM_CNT_RST  = 2'h2;

	// Status register fields
	localparam int          STAT_DEL_LSB = 8;

	// Mode register fields
	localparam int          MODE_DIR     = 0;
	localparam int          MODE_SIL_LSB = 1;
	localparam int          MODE_SOC     = 3;
	localparam int          MODE_EXT_LSB = 4;

	// Timing register fields
	localparam int          TIM_ON_LSB   = 0;
	localparam int          TIM_OFF_LSB  = 8;
	localparam int          TIM_CYC_LSB  = 16;

	// Percentage scaling per sensor (reading units per percent)
	localparam logic [7:0]  PCT_MUL_CO2  = 8'h14;
	localparam logic [7:0]  PCT_MUL_HUM  = 8'h01;

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SIL_NONE = 2'b00,
		SIL_ON   = 2'b01,
		SIL_OFF  = 2'b10,
		SIL_RSV  = 2'b11
	} lvm_sil_t;

	typedef enum logic [1:0] {
		EXT_NONE  = 2'b00,
		EXT_ABS   = 2'b01,
		EXT_PCT   = 2'b10,
		EXT_TEACH = 2'b11
	} lvm_ext_t;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] level;
		logic [15:0] hyst;
		logic        dir_over;
		lvm_sil_t    silent;
		logic        soc;
		lvm_ext_t    ext_sel;
		logic [7:0]  on_dly;
		logic [7:0]  off_dly;
		logic [7:0]  cyc;
	} lvm_cfg_t;

	typedef struct packed {
		logic        valid;
		logic [2:0]  idx;
		lvm_ext_t    kind;
		logic [15:0] data;
	} lvm_obj_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] value;
	} lvm_meas_t;

	localparam logic [15:0] LEVEL_RST [N_LIM] = '{16'h0190, 16'h0320, 16'h04b0,
	                                              16'h0640, 16'h0032, 16'h0046};
	localparam logic [15:0] HYST_RST    = 16'h0032;

endpackage

//--- hdl/lvm_limit_value_monitor.sv
// Limit value monitor: six hysteresis limits with delays, change and cyclic telegrams
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns

// What this block does
// - Set/clear limit state with hysteresis per direction
// - Silent state suppresses cyclic sending until opposite
// - Cyclic period is factor times ten seconds
// - Leaving silent state resends only with send on change set; cycling resumes
// - External limit as absolute or percentage object
// - Teach one copies latest reading; zeros ignored
// - External or taught limit overrides configured one
// - Configuration reload drops external limit values
// - Four carbon dioxide and two humidity limits
// - Rising uses on delay, falling uses off
// - Zero delay makes delayed state follow immediately
// - Delay timer expiry updates state; sent only with send on change set and the new state not silent
// - Reverting before expiry stops timer, no telegram
// - Send on change sends every delayed transition into a non-silent state
// - Recurring event after silent opposite sends again only with send on change set
// - Change telegrams leave the cyclic period alone
// - Silent state never sent, neither change nor cyclic
// - Cycle factor zero disables periodic sending
module lvm_limit_value_monitor #(
	parameter int TICK_CYCLES = lvm_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire  logic                         core_clk,
	input  wire  logic                         sys_rst,
	// Register port
	input  wire  logic [lvm_pkg::ADDR_W-1:0]   reg_addr,
	input  wire  logic [31:0]                  reg_wdata,
	input  wire  logic                         reg_wr,
	input  wire  logic                         reg_rd,
	output logic       [31:0]                  reg_rdata,
	// Measured values
	input  wire  lvm_pkg::lvm_meas_t           co2_meas,
	input  wire  lvm_pkg::lvm_meas_t           hum_meas,
	// External limit objects from the bus
	input  wire  lvm_pkg::lvm_obj_t            ext_obj,
	// Limit objects towards the bus
	output logic [lvm_pkg::N_LIM-1:0]          tel_send,
	output logic [lvm_pkg::N_LIM-1:0]          limit_level
);

	// ----------------------------------------------------------------
	// Control registers and bus decode
	// ----------------------------------------------------------------
	logic [2:0]  co2_cnt_q;
	logic [1:0]  hum_cnt_q;
	logic        reinit_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [15:0] co2_val_q;
	logic [15:0] hum_val_q;

	wire         ctrl_wr   = reg_wr && (reg_addr == lvm_pkg::ADDR_CTRL);
	wire  [3:0]  bank      = reg_addr[7:4];
	wire  [3:0]  bank_ofs  = reg_addr[3:0];
	wire  [3:0]  lim_sel   = bank - lvm_pkg::LIM_BANK0;
	wire         lim_hit   = (bank >= lvm_pkg::LIM_BANK0) &&
	                         (lim_sel < 4'(lvm_pkg::N_LIM));

	// Reload pulse acts as reinitialisation of every limit and the tick
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			co2_cnt_q <= lvm_pkg::CO2_CNT_RST;
			hum_cnt_q <= lvm_pkg::HUM_CNT_RST;
			reinit_q  <= 1'b1;
		end else begin
			reinit_q <= ctrl_wr && reg_wdata[lvm_pkg::CTRL_RELOAD];
			if (ctrl_wr) begin
				co2_cnt_q <= reg_wdata[lvm_pkg::CTRL_CO2_LSB +: 3];
				hum_cnt_q <= reg_wdata[lvm_pkg::CTRL_HUM_LSB +: 2];
			end
		end
	end

	// Latest readings, also the source of taught limits
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			co2_val_q <= 16'h0000;
			hum_val_q <= 16'h0000;
		end else begin
			if (co2_meas.valid)
				co2_val_q <= co2_meas.value;
			if (hum_meas.valid)
				hum_val_q <= hum_meas.value;
		end
	end

	// ----------------------------------------------------------------
	// Common time base
	// ----------------------------------------------------------------
	localparam logic [lvm_pkg::TICK_CNT_W-1:0] TICK_LAST =
		lvm_pkg::TICK_CNT_W'(TICK_CYCLES - 1);

	logic [lvm_pkg::TICK_CNT_W-1:0] tick_cnt_q;
	wire                            tick = (tick_cnt_q == TICK_LAST);

	// Restarts on reload so every timer begins from a whole tick
	always_ff @(posedge core_clk) begin
		if (sys_rst || reinit_q || tick)
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + 1'b1;
	end

	// ----------------------------------------------------------------
	// Per-limit channels
	// ----------------------------------------------------------------
	logic [31:0] lim_rd [lvm_pkg::N_LIM];
	logic [lvm_pkg::N_LIM-1:0] int_st;

	genvar gi;
	generate
		for (gi = 0; gi < lvm_pkg::N_LIM; gi++) begin : g_lim
			localparam bit IS_CO2 = (gi < lvm_pkg::N_CO2);

			lvm_pkg::lvm_cfg_t cfg_q;
			logic [15:0]       ext_lvl_q;
			logic              ext_act_q;
			logic              int_q;
			logic              del_q;
			logic              run_q;
			logic [7:0]        dly_q;
			logic [15:0]       cyc_q;
			logic              send_q;

			// Enable by configured count of active limits
			wire enabled = IS_CO2 ? (3'(gi) < co2_cnt_q)
			                      : (2'(gi - lvm_pkg::N_CO2) < hum_cnt_q);

			// Register writes for this limit
			wire sel    = lim_hit && (lim_sel == 4'(gi));
			wire wr_lvl = reg_wr && sel && (bank_ofs == lvm_pkg::OFS_LEVEL);
			wire wr_hys = reg_wr && sel && (bank_ofs == lvm_pkg::OFS_HYST);
			wire wr_mod = reg_wr && sel && (bank_ofs == lvm_pkg::OFS_MODE);
			wire wr_tim = reg_wr && sel && (bank_ofs == lvm_pkg::OFS_TIMING);

			// External objects addressed to this limit
			wire        obj_hit  = ext_obj.valid && (ext_obj.idx == 3'(gi)) &&
			                       (ext_obj.kind == cfg_q.ext_sel);
			wire [15:0] meas     = IS_CO2 ? co2_val_q : hum_val_q;
			wire [7:0]  pct_mul  = IS_CO2 ? lvm_pkg::PCT_MUL_CO2 : lvm_pkg::PCT_MUL_HUM;
			// Widen before the product so percentages above a byte of units survive
			wire [15:0] pct_lvl  = 16'(ext_obj.data[7:0]) * 16'(pct_mul);
			wire        take_abs = obj_hit && (cfg_q.ext_sel == lvm_pkg::EXT_ABS);
			wire        take_pct = obj_hit && (cfg_q.ext_sel == lvm_pkg::EXT_PCT);
			wire        take_tch = obj_hit && (cfg_q.ext_sel == lvm_pkg::EXT_TEACH) &&
			                       ext_obj.data[0];
			wire [15:0] new_ext  = take_abs ? ext_obj.data :
			                       take_pct ? pct_lvl : meas;

			// Threshold and hysteresis comparison
			wire [15:0] lvl      = ext_act_q ? ext_lvl_q : cfg_q.level;
			wire [16:0] hi_band  = {1'b0, lvl} + {1'b0, cfg_q.hyst};
			wire [15:0] lo_band  = (cfg_q.hyst > lvl) ? 16'h0000 : lvl - cfg_q.hyst;
			wire        set_c    = cfg_q.dir_over ? (meas > lvl) : (meas < lvl);
			wire        clr_c    = cfg_q.dir_over ? (meas < lo_band)
			                                      : ({1'b0, meas} > hi_band);
			wire        int_d    = set_c ? 1'b1 : (clr_c ? 1'b0 : int_q);

			// Delay selection by direction of the pending change
			wire [7:0]  dly_cfg  = int_q ? cfg_q.on_dly : cfg_q.off_dly;
			wire        pend     = (int_q != del_q);
			wire        expire   = run_q && tick && (dly_q == 8'h01);
			wire        upd      = pend && ((dly_cfg == 8'h00) || expire);

			// Silent state handling
			wire        sil_on   = (cfg_q.silent == lvm_pkg::SIL_ON);
			wire        sil_off  = (cfg_q.silent == lvm_pkg::SIL_OFF);
			wire        new_sil  = int_q ? sil_on : sil_off;
			wire        cur_sil  = del_q ? sil_on : sil_off;
			wire        was_sup  = del_q ? sil_off : sil_on;

			// Cyclic period in ticks; factor zero disables
			wire [15:0] period   = 16'(cfg_q.cyc * lvm_pkg::BASE_TICKS);
			wire        cyc_on   = (cfg_q.cyc != 8'h00);
			wire        cyc_hit  = cyc_on && tick && (cyc_q <= 16'h0001);
			wire        chg_send = upd && !new_sil && (cfg_q.soc || was_sup);
			wire        cyc_send = cyc_hit && !cur_sil && !upd;

			// Configuration store
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					cfg_q          <= '0;
					cfg_q.level    <= lvm_pkg::LEVEL_RST[gi];
					cfg_q.hyst     <= lvm_pkg::HYST_RST;
					cfg_q.soc      <= 1'b1;
				end else begin
					if (wr_lvl)
						cfg_q.level <= reg_wdata[15:0];
					if (wr_hys)
						cfg_q.hyst <= reg_wdata[15:0];
					if (wr_mod) begin
						cfg_q.dir_over <= reg_wdata[lvm_pkg::MODE_DIR];
						cfg_q.silent   <= lvm_pkg::lvm_sil_t'(reg_wdata[lvm_pkg::MODE_SIL_LSB +: 2]);
						cfg_q.soc      <= reg_wdata[lvm_pkg::MODE_SOC];
						cfg_q.ext_sel  <= lvm_pkg::lvm_ext_t'(reg_wdata[lvm_pkg::MODE_EXT_LSB +: 2]);
					end
					if (wr_tim) begin
						cfg_q.on_dly  <= reg_wdata[lvm_pkg::TIM_ON_LSB +: 8];
						cfg_q.off_dly <= reg_wdata[lvm_pkg::TIM_OFF_LSB +: 8];
						cfg_q.cyc     <= reg_wdata[lvm_pkg::TIM_CYC_LSB +: 8];
					end
				end
			end

			// External override; a reload brings the configured level back
			always_ff @(posedge core_clk) begin
				if (sys_rst || reinit_q) begin
					ext_act_q <= 1'b0;
					ext_lvl_q <= 16'h0000;
				end else if (take_abs || take_pct || take_tch) begin
					ext_act_q <= 1'b1;
					ext_lvl_q <= new_ext;
				end
			end

			// Internal and delayed states with the delay timer
			always_ff @(posedge core_clk) begin
				if (sys_rst || reinit_q || !enabled) begin
					int_q <= 1'b0;
					del_q <= 1'b0;
					run_q <= 1'b0;
					dly_q <= 8'h00;
				end else begin
					int_q <= int_d;
					if (!pend) begin
						run_q <= 1'b0;
					end else if (upd) begin
						del_q <= int_q;
						run_q <= 1'b0;
					end else if (!run_q) begin
						run_q <= 1'b1;
						dly_q <= dly_cfg;
					end else if (tick) begin
						dly_q <= dly_q - 8'h01;
					end
				end
			end

			// Cycle timer runs freely; change telegrams do not touch it
			always_ff @(posedge core_clk) begin
				if (sys_rst || reinit_q || !enabled || !cyc_on)
					cyc_q <= period;
				else if (cyc_hit)
					cyc_q <= period;
				else if (tick)
					cyc_q <= cyc_q - 16'h0001;
			end

			// Telegram strobe, one cycle per send
			always_ff @(posedge core_clk) begin
				if (sys_rst || reinit_q || !enabled)
					send_q <= 1'b0;
				else
					send_q <= chg_send || cyc_send;
			end

			assign tel_send[gi]    = send_q;
			assign limit_level[gi] = del_q;
			assign int_st[gi]      = int_q;

			// Read-back word selected by offset
			assign lim_rd[gi] =
				(bank_ofs == lvm_pkg::OFS_LEVEL)  ? {16'h0000, lvl} :
				(bank_ofs == lvm_pkg::OFS_HYST)   ? {16'h0000, cfg_q.hyst} :
				(bank_ofs == lvm_pkg::OFS_MODE)   ? {26'h0, cfg_q.ext_sel, cfg_q.soc,
				                                     cfg_q.silent, cfg_q.dir_over} :
				(bank_ofs == lvm_pkg::OFS_TIMING) ? {8'h00, cfg_q.cyc, cfg_q.off_dly,
				                                     cfg_q.on_dly} :
				32'h0000_0000;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read data, valid in the cycle after the strobe
	// ----------------------------------------------------------------
	wire [31:0] ctrl_rd = {23'h0, 1'b0, 2'b00, hum_cnt_q, 1'b0, co2_cnt_q};
	wire [31:0] stat_rd = {16'h0, 2'b00, limit_level, 2'b00, int_st};

	// Unmapped addresses answer zero
	assign rdata_d = !reg_rd                          ? 32'h0000_0000 :
	                 (reg_addr == lvm_pkg::ADDR_CTRL)   ? ctrl_rd :
	                 (reg_addr == lvm_pkg::ADDR_STATUS) ? stat_rd :
	                 (lim_hit && (bank_ofs[1:0] == 2'b00)) ? lim_rd[lim_sel[2:0]] :
	                 32'h0000_0000;

	always_ff @(posedge core_clk) begin
		if (sys_rst)
			rdata_q <= 32'h0000_0000;
		else
			rdata_q <= rdata_d;
	end

	assign reg_rdata = rdata_q;

endmodule

//--- dv/lvm_bus_node.sv
// Push-button style bus node that hands limit objects to the monitor
`timescale 1ns/1ns
module lvm_bus_node #(
	parameter int HOLD = 30
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	// Press request and object towards the monitor
	input  wire lvm_pkg::lvm_obj_t req,
	output lvm_pkg::lvm_obj_t      obj
);
	// ----
	// Delayed send
	// ----
	lvm_pkg::lvm_obj_t pend_q;
	int                cnt_q;

	// Delay the press by HOLD cycles before sending; even a one-cycle touch is sent
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pend_q <= '0;
			cnt_q  <= 0;
		end else if (req.valid) begin
			pend_q <= req;
			cnt_q  <= HOLD;
		end else if (cnt_q > 0) begin
			cnt_q <= cnt_q - 1;
		end
	end

	// One-cycle object; payload scrambled between objects so stale data never matches
	assign obj = (cnt_q == 1) ? pend_q : '{1'b0, ~pend_q.idx, ~pend_q.kind, ~pend_q.data};
endmodule

//--- dv/lvm_checker_assertions.sv
// Port assertions of the limit value monitor
`timescale 1ns/1ns
module lvm_checker (
	// Clock and reset
	input wire logic                        core_clk,
	input wire logic                        sys_rst,
	// Register port
	input wire logic [lvm_pkg::ADDR_W-1:0]  reg_addr,
	input wire logic                        reg_rd,
	input wire logic [31:0]                 reg_rdata,
	// Limit objects
	input wire logic [lvm_pkg::N_LIM-1:0]   tel_send,
	input wire logic [lvm_pkg::N_LIM-1:0]   limit_level
);
	// ----
	// Properties
	// ----
	default clocking @(posedge core_clk); endclocking

	AST_RDATA_IDLE: assert property (disable iff (sys_rst)
		!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside slot");
	AST_RST_CLEAR: assert property (
		sys_rst |=> tel_send == 6'h0 && limit_level == 6'h0) else $error("reset not clean");
	AST_RST_QUIET: assert property (disable iff (sys_rst)
		$fell(sys_rst) |-> (tel_send == 6'h0) [*3]) else $error("send right after reset");
	AST_RST_LEVEL: assert property (disable iff (sys_rst)
		$fell(sys_rst) |-> limit_level == 6'h0 ##1 limit_level == 6'h0) else $error("level set");
	AST_STATUS_DELAYED: assert property (disable iff (sys_rst)
		$past(reg_rd && reg_addr == lvm_pkg::ADDR_STATUS) |-> reg_rdata[13:8] == $past(limit_level))
		else $error("status disagrees with level");
	AST_STATUS_RSV: assert property (disable iff (sys_rst)
		$past(reg_rd && reg_addr == lvm_pkg::ADDR_STATUS) |-> reg_rdata[31:14] == 18'h0
		&& reg_rdata[7:6] == 2'h0) else $error("status spare bits set");
	AST_RELOAD_READ0: assert property (disable iff (sys_rst)
		$past(reg_rd && reg_addr == lvm_pkg::ADDR_CTRL) |-> reg_rdata[8] == 1'b0)
		else $error("reload bit reads one");
	AST_UNMAPPED: assert property (disable iff (sys_rst)
		$past(reg_rd && reg_addr == 8'h08) |-> reg_rdata == 32'h0) else $error("unmapped read");

	// Main scenarios reached
	COV_SEND: cover property (tel_send[0]);
	COV_OFF: cover property ($fell(limit_level[1]));
	COV_CYC: cover property (tel_send[2] && !$changed(limit_level[2]));
endmodule

bind lvm_limit_value_monitor lvm_checker i_chk (
	.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .tel_send(tel_send), .limit_level(limit_level));

//--- dv/tb_top.sv
// Self-checking bench of the limit value monitor
`timescale 1ns/1ns
module tb_top;
	// ----
	// Signals
	// ----
	logic               core_clk, sys_rst, reg_wr, reg_rd;
	logic [7:0]         reg_addr;
	logic [31:0]        reg_wdata, reg_rdata;
	lvm_pkg::lvm_meas_t co2_meas, hum_meas;
	lvm_pkg::lvm_obj_t  ext_obj, req;
	logic [5:0]         tel_send, limit_level;
	int                 errors, num_checks, cyc, t0;
	int                 cnt [6];
	int                 st [6];

	lvm_limit_value_monitor #(.TICK_CYCLES(10)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .co2_meas(co2_meas), .hum_meas(hum_meas), .ext_obj(ext_obj),
		.tel_send(tel_send), .limit_level(limit_level));
	lvm_bus_node #(.HOLD(30)) i_node (.core_clk(core_clk), .sys_rst(sys_rst), .req(req),
		.obj(ext_obj));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Telegram count and cycle stamp per limit
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		for (int i = 0; i < 6; i++) begin
			if (tel_send[i] === 1'b1) begin
				cnt[i] <= cnt[i] + 1;
				st[i]  <= cyc;
			end
		end
	end

	// ----
	// Tasks
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	// Gap cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
		@(posedge core_clk);
	endtask

	task automatic mc(input logic [15:0] v);
		co2_meas <= '{1'b1, v};
		repeat (8) @(posedge core_clk);
	endtask

	task automatic ob(input logic [2:0] i, input lvm_pkg::lvm_ext_t k, input logic [15:0] d);
		req <= '{1'b1, i, k, d};
		@(posedge core_clk);
		req.valid <= 1'b0;
		repeat (36) @(posedge core_clk);
	endtask

	// Bounded wait for the next telegram of one limit
	task automatic ws(input int i);
		int c0;
		c0 = cnt[i];
		for (int k = 0; k < 1500 && cnt[i] == c0; k++) @(posedge core_clk);
	endtask

	task automatic summarize;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ----
	// Tests
	// ----
	initial begin
		repeat (60000) @(posedge core_clk);
		errors++;
		summarize();
	end

	initial begin
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h0;
		reg_wdata = 32'h0;
		co2_meas = '{1'b1, 16'd2000};
		hum_meas = '{1'b1, 16'd150};
		req = '0;
		cyc = 0;
		cnt = '{default: 0};
		st = '{default: 0};
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge core_clk);
		rc(8'h00, 32'h24);
		rc(8'h10, 32'h190);
		rc(8'h14, 32'h32);
		rc(8'h18, 32'h8);
		rc(8'h08, 32'h0);
		$display("reset test done");
		mc(16'd399);
		chk(limit_level, 6'h0f);
		chk(cnt[0], 1);
		mc(16'd440);
		chk(limit_level[0], 1'b1);
		mc(16'd451);
		chk(limit_level, 6'h0e);
		chk(cnt[0], 2);
		$display("hysteresis test done");
		wr(8'h2c, 32'h300);
		mc(16'd900);
		chk(limit_level[1], 1'b1);
		repeat (40) @(posedge core_clk);
		chk(limit_level[1], 1'b0);
		chk(cnt[1], 2);
		wr(8'h2c, 32'h305);
		mc(16'd700);
		mc(16'd900);
		repeat (60) @(posedge core_clk);
		chk(limit_level[1], 1'b0);
		chk(cnt[1], 2);
		$display("delay test done");
		wr(8'h3c, 32'h10000);
		ws(2);
		t0 = st[2];
		repeat (300) @(posedge core_clk);
		mc(16'd1300);
		chk(limit_level[2], 1'b0);
		ws(2);
		chk(st[2] - t0, 1000);
		wr(8'h3c, 32'h0);
		t0 = cnt[2];
		repeat (1100) @(posedge core_clk);
		chk(cnt[2], t0);
		$display("cyclic test done");
		wr(8'h48, 32'hc);
		wr(8'h4c, 32'h10000);
		mc(16'd1700);
		t0 = cnt[3];
		repeat (2100) @(posedge core_clk);
		chk(cnt[3], t0);
		mc(16'd1500);
		chk(cnt[3], t0 + 1);
		ws(3);
		chk(cnt[3], t0 + 2);
		$display("silent test done");
		wr(8'h58, 32'h18);
		ob(3'd4, lvm_pkg::EXT_ABS, 16'h00c8);
		rc(8'h50, 32'hc8);
		ob(3'd4, lvm_pkg::EXT_PCT, 16'h0010);
		rc(8'h50, 32'hc8);
		wr(8'h58, 32'h28);
		ob(3'd4, lvm_pkg::EXT_PCT, 16'h000a);
		rc(8'h50, 32'ha);
		wr(8'h58, 32'h38);
		ob(3'd4, lvm_pkg::EXT_TEACH, 16'h0);
		rc(8'h50, 32'ha);
		ob(3'd4, lvm_pkg::EXT_TEACH, 16'h1);
		rc(8'h50, 32'h96);
		wr(8'h18, 32'h28);
		ob(3'd0, lvm_pkg::EXT_PCT, 16'h0005);
		rc(8'h10, 32'h64);
		ob(3'd0, lvm_pkg::EXT_PCT, 16'h0010);
		rc(8'h10, 32'h140);
		wr(8'h00, 32'h124);
		rc(8'h50, 32'h32);
		rc(8'h10, 32'h190);
		$display("external test done");
		summarize();
	end
endmodule
